// file: design/gpa_pkg.sv
// register map, field masks and reset values of the parallel port block
package gpa_pkg;

   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_PA_LATCH = 4'h0;
   localparam logic [3:0] IDX_PA_DIR   = 4'h4;
   localparam logic [3:0] IDX_PB_DIR   = 4'h5;
   localparam logic [3:0] IDX_PC_DIR   = 4'h6;
   localparam logic [3:0] IDX_PD_DIR   = 4'h7;
   localparam logic [3:0] IDX_PE_LATCH = 4'h8;
   localparam logic [3:0] IDX_PE_DIR   = 4'hc;
   localparam logic [3:0] IDX_PA_PU    = 4'hd;
   localparam logic [3:0] IDX_PC_PU    = 4'he;
   localparam logic [3:0] IDX_PD_PU    = 4'hf;

   // bus geometry
   localparam int ADDR_W  = 6;
   localparam int DATA_W  = 32;
   localparam int IDX_LSB = 2;
   localparam int PA_PINS = 4;

   // implemented bits of each register
   localparam logic [7:0] MASK_PA = 8'h0f;
   localparam logic [7:0] MASK_PB = 8'h3f;
   localparam logic [7:0] MASK_PC = 8'h03;
   localparam logic [7:0] MASK_PD = 8'h7f;
   localparam logic [7:0] MASK_PE = 8'h03;

   // reset values
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PU  = 8'h00;

   // bus answer sequencer
   typedef enum logic [0:0] {
      bus_idle   = 1'b0,
      bus_answer = 1'b1
   } gpa_bus_state_type;

endpackage

// file: design/gpa_port_regs.sv
// port A pins with latch, direction and pull-up, plus port B to E registers
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module gpa_port_regs
   import gpa_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [ADDR_W-1:0]    avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [DATA_W-1:0]    avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [DATA_W-1:0]    avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic [PA_PINS-1:0]   port_a_pin_in,
   output logic      [PA_PINS-1:0]   port_a_pin_out,
   output logic      [PA_PINS-1:0]   port_a_pin_oe,
   output logic      [PA_PINS-1:0]   port_a_pullup_on,
   input  wire logic [PA_PINS-1:0]   keypad_irq_pin_enables,
   output logic      [PA_PINS-1:0]   keypad_inputs,
   output logic      [7:0]           port_b_direction_out,
   output logic      [7:0]           port_c_direction_out,
   output logic      [7:0]           port_d_direction_out,
   output logic      [7:0]           port_e_latch_out,
   output logic      [7:0]           port_e_direction_out,
   output logic      [7:0]           port_c_pullup_out,
   output logic      [7:0]           port_d_pullup_out
);

   // register storage
   logic [7:0]          port_a_latch;
   logic [7:0]          port_a_direction;
   logic [7:0]          port_b_direction;
   logic [7:0]          port_c_direction;
   logic [7:0]          port_d_direction;
   logic [7:0]          port_e_latch;
   logic [7:0]          port_e_direction;
   logic [7:0]          port_a_pullup_enable;
   logic [7:0]          port_c_pullup_enable;
   logic [7:0]          port_d_pullup_enable;

   // pin synchroniser and bus sequencer
   logic [PA_PINS-1:0]  pin_meta;
   logic [PA_PINS-1:0]  pin_sync;
   gpa_bus_state_type   bus_state;
   gpa_bus_state_type   next_bus_state;
   logic [DATA_W-1:0]   next_readdata;

   // decode wires
   wire logic [3:0]     idx      = avs_address[IDX_LSB+3:IDX_LSB];
   wire logic           aligned  = (avs_address[IDX_LSB-1:0] == 2'h0);
   wire logic           req      = avs_read | avs_write;
   wire logic           accept   = req & (bus_state == bus_answer);
   wire logic           wr_fire  = accept & avs_write & avs_byteenable[0] & aligned;
   wire logic [7:0]     wbyte    = avs_writedata[7:0];
   wire logic           sel_pa_l = (idx == IDX_PA_LATCH);
   wire logic           sel_pa_d = (idx == IDX_PA_DIR);
   wire logic           sel_pb_d = (idx == IDX_PB_DIR);
   wire logic           sel_pc_d = (idx == IDX_PC_DIR);
   wire logic           sel_pd_d = (idx == IDX_PD_DIR);
   wire logic           sel_pe_l = (idx == IDX_PE_LATCH);
   wire logic           sel_pe_d = (idx == IDX_PE_DIR);
   wire logic           sel_pa_u = (idx == IDX_PA_PU);
   wire logic           sel_pc_u = (idx == IDX_PC_PU);
   wire logic           sel_pd_u = (idx == IDX_PD_PU);
   wire logic           sel_any  = sel_pa_l | sel_pa_d | sel_pb_d | sel_pc_d | sel_pd_d
                                 | sel_pe_l | sel_pe_d | sel_pa_u | sel_pc_u | sel_pd_u;

   // effective per-pin control after peripheral override
   wire logic [PA_PINS-1:0] dir_a   = port_a_direction[PA_PINS-1:0];
   wire logic [PA_PINS-1:0] pu_a    = port_a_pullup_enable[PA_PINS-1:0];
   wire logic [PA_PINS-1:0] eff_dir = dir_a & ~keypad_irq_pin_enables;
   logic      [PA_PINS-1:0] pa_read;

   // bus sequencer: one wait cycle, then the answer
   always_comb
   begin
      next_bus_state = bus_idle;
      case (bus_state)
         bus_idle:   next_bus_state = req ? bus_answer : bus_idle;
         bus_answer: next_bus_state = bus_idle;
         default:    next_bus_state = bus_idle;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         bus_state <= bus_idle;
      else
         bus_state <= next_bus_state;
   end

   assign avs_waitrequest = req & (bus_state == bus_idle);

   // two flops before any logic sees the pads
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= port_a_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // per pin read source: latch when the direction bit is set, pad otherwise; keypad override is not taken into account
   generate
      for (genvar i = 0; i < PA_PINS; i++)
      begin : g_pa_read
         assign pa_read[i] = dir_a[i] ? port_a_latch[i] : pin_sync[i];
      end
   endgenerate

   // read mux; unmapped indices and misaligned reads give zero
   always_comb
   begin
      next_readdata = '0;
      if (aligned)
      begin
         case (idx)
            IDX_PA_LATCH: next_readdata[7:0] = {4'h0, pa_read};
            IDX_PA_DIR:   next_readdata[7:0] = port_a_direction;
            IDX_PB_DIR:   next_readdata[7:0] = port_b_direction;
            IDX_PC_DIR:   next_readdata[7:0] = port_c_direction;
            IDX_PD_DIR:   next_readdata[7:0] = port_d_direction;
            IDX_PE_LATCH: next_readdata[7:0] = port_e_latch;
            IDX_PE_DIR:   next_readdata[7:0] = port_e_direction;
            IDX_PA_PU:    next_readdata[7:0] = port_a_pullup_enable;
            IDX_PC_PU:    next_readdata[7:0] = port_c_pullup_enable;
            IDX_PD_PU:    next_readdata[7:0] = port_d_pullup_enable;
            default:      next_readdata = '0;
         endcase
      end
   end

   // read data captured in the wait cycle, held to the answer edge
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         avs_readdata <= '0;
      else if (avs_read && bus_state == bus_idle)
         avs_readdata <= next_readdata;
   end

   // latches carry no reset so a system reset leaves them intact
   always_ff @(posedge clk)
   begin
      if (wr_fire && sel_pa_l)
         port_a_latch <= wbyte & MASK_PA;
      if (wr_fire && sel_pe_l)
         port_e_latch <= wbyte & MASK_PE;
   end

   // direction registers; cleared so every pin wakes as an input
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         port_a_direction <= RST_DIR;
         port_b_direction <= RST_DIR;
         port_c_direction <= RST_DIR;
         port_d_direction <= RST_DIR;
         port_e_direction <= RST_DIR;
      end
      else if (wr_fire)
      begin
         if (sel_pa_d)
            port_a_direction <= wbyte & MASK_PA;
         if (sel_pb_d)
            port_b_direction <= wbyte & MASK_PB;
         if (sel_pc_d)
            port_c_direction <= wbyte & MASK_PC;
         if (sel_pd_d)
            port_d_direction <= wbyte & MASK_PD;
         if (sel_pe_d)
            port_e_direction <= wbyte & MASK_PE;
      end
   end

   // pull-up enable registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         port_a_pullup_enable <= RST_PU;
         port_c_pullup_enable <= RST_PU;
         port_d_pullup_enable <= RST_PU;
      end
      else if (wr_fire)
      begin
         if (sel_pa_u)
            port_a_pullup_enable <= wbyte & MASK_PA;
         if (sel_pc_u)
            port_c_pullup_enable <= wbyte & MASK_PC;
         if (sel_pd_u)
            port_d_pullup_enable <= wbyte & MASK_PD;
      end
   end

   // pad drive; pull-up is gated by direction, not by a clocked copy,
   // so it drops in the same cycle the pin turns to output
   assign port_a_pin_out   = port_a_latch[PA_PINS-1:0];
   assign port_a_pin_oe    = eff_dir;
   assign port_a_pullup_on = pu_a & ~eff_dir;

   // keypad inputs see the pad only where enabled; others read low
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         keypad_inputs <= '0;
      else
         keypad_inputs <= pin_sync & keypad_irq_pin_enables;
   end

   // the other ports' settings go to their own pad logic
   assign port_b_direction_out = port_b_direction;
   assign port_c_direction_out = port_c_direction;
   assign port_d_direction_out = port_d_direction;
   assign port_e_latch_out     = port_e_latch;
   assign port_e_direction_out = port_e_direction;
   assign port_c_pullup_out    = port_c_pullup_enable;
   assign port_d_pullup_out    = port_d_pullup_enable;

   // checks on the design's own outputs and registers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   wire logic rd_acc = accept & avs_read & aligned;

   a_dir_reset_clear: assert property (
      $rose(reset_n) |-> (port_a_direction == 8'h00) && (port_a_pin_oe == 4'h0))
      else $error("port a direction not cleared by reset");

   a_oe_needs_dir: assert property (
      ((port_a_pin_oe & ~dir_a) == 4'h0)
      && ((port_a_pin_oe & keypad_irq_pin_enables) == 4'h0))
      else $error("pin driven without output direction");

   // a keypad override turns the pin into an input, so the pull-up may follow it
   a_pullup_gating: assert property (
      ((port_a_pullup_on & ~pu_a) == 4'h0)
      && ((port_a_pullup_on & dir_a & ~keypad_irq_pin_enables) == 4'h0))
      else $error("pull-up on while disabled or output");

   a_pullup_drop_now: assert property (
      $rose(port_a_pin_oe[0]) |-> !port_a_pullup_on[0])
      else $error("pull-up lingers after output turn-on");

   a_read_latch_bits: assert property (
      (rd_acc && sel_pa_l) |-> ((avs_readdata[3:0] & dir_a) == (port_a_latch[3:0] & dir_a)))
      else $error("output bit read did not return latch");

   a_read_pin_bits: assert property (
      (rd_acc && sel_pa_l) |-> ((avs_readdata[3:0] & ~dir_a) == ($past(pin_sync) & ~dir_a)))
      else $error("input bit read did not return pin level");

   a_latch_write_any: assert property (
      (wr_fire && sel_pa_l) |=> (port_a_pin_out == $past(avs_writedata[3:0])))
      else $error("port a latch write lost");

   a_wait_one_cycle: assert property (
      (req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("answer not given after one wait cycle");

   a_upper_zero: assert property (
      rd_acc |-> (avs_readdata[31:8] == 24'h0)
      && (!sel_pa_l || avs_readdata[7:4] == 4'h0)
      && (!sel_pb_d || avs_readdata[7:6] == 2'h0))
      else $error("unimplemented bits read nonzero");

   a_pb_dir_write: assert property (
      (wr_fire && sel_pb_d) |=> (port_b_direction_out == ($past(wbyte) & 8'h3f)))
      else $error("port b direction write wrong");

   a_keypad_follow: assert property (
      keypad_irq_pin_enables[0] [*3] |-> (keypad_inputs[0] == $past(pin_sync[0])))
      else $error("keypad input does not follow pin");

   // keypad side sees nothing from pins whose function is off
   a_keypad_gated: assert property (
      ((keypad_inputs & ~$past(keypad_irq_pin_enables)) == 4'h0))
      else $error("keypad input passed a disabled pin");

   // every register takes the masked byte on the edge after its write
   a_pa_dir_write: assert property (
      (wr_fire && sel_pa_d) |=> (port_a_direction == ($past(wbyte) & MASK_PA)))
      else $error("port a direction write wrong");

   a_pc_dir_write: assert property (
      (wr_fire && sel_pc_d) |=> (port_c_direction_out == ($past(wbyte) & MASK_PC)))
      else $error("port c direction write wrong");

   a_pd_dir_write: assert property (
      (wr_fire && sel_pd_d) |=> (port_d_direction_out == ($past(wbyte) & MASK_PD)))
      else $error("port d direction write wrong");

   a_pe_latch_write: assert property (
      (wr_fire && sel_pe_l) |=> (port_e_latch_out == ($past(wbyte) & MASK_PE)))
      else $error("port e latch write wrong");

   a_pe_dir_write: assert property (
      (wr_fire && sel_pe_d) |=> (port_e_direction_out == ($past(wbyte) & MASK_PE)))
      else $error("port e direction write wrong");

   a_pa_pu_write: assert property (
      (wr_fire && sel_pa_u) |=> (port_a_pullup_enable == ($past(wbyte) & MASK_PA)))
      else $error("port a pull-up enable write wrong");

   a_pc_pu_write: assert property (
      (wr_fire && sel_pc_u) |=> (port_c_pullup_out == ($past(wbyte) & MASK_PC)))
      else $error("port c pull-up enable write wrong");

   a_pd_pu_write: assert property (
      (wr_fire && sel_pd_u) |=> (port_d_pullup_out == ($past(wbyte) & MASK_PD)))
      else $error("port d pull-up enable write wrong");

   // without a write aimed at them the settings stay put
   a_pa_dir_hold: assert property (
      !(wr_fire && sel_pa_d) |=> $stable(port_a_direction))
      else $error("port a direction changed without a write");

   a_pb_dir_hold: assert property (
      !(wr_fire && sel_pb_d) |=> $stable(port_b_direction))
      else $error("port b direction changed without a write");

   a_pe_dir_hold: assert property (
      !(wr_fire && sel_pe_d) |=> $stable(port_e_direction))
      else $error("port e direction changed without a write");

   a_pa_pu_hold: assert property (
      !(wr_fire && sel_pa_u) |=> $stable(port_a_pullup_enable))
      else $error("port a pull-up enable changed without a write");

   // refused accesses are still answered, with zero
   a_misaligned_zero: assert property (
      (accept && avs_read && !aligned) |-> (avs_readdata == 32'h0))
      else $error("misaligned read returned nonzero");

   a_unmapped_zero: assert property (
      (rd_acc && !sel_any) |-> (avs_readdata == 32'h0))
      else $error("unmapped read returned nonzero");

   c_read_port_a: cover property (rd_acc && sel_pa_l && dir_a != 4'h0);
   c_output_turn_on: cover property ($rose(port_a_pin_oe[0]));
   c_write_port_a: cover property (wr_fire && sel_pa_l);
   c_keypad_override: cover property (|(dir_a & keypad_irq_pin_enables));
   c_pullup_active: cover property (port_a_pullup_on != 4'h0);

endmodule

// file: test/gpa_pad_model.sv
// pad model for port A: resolves each pin from device drive, outside drive and pull-up
`timescale 1ns/100ps

module gpa_pad_model
(
   input  wire logic       clk,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pullup_on,
   input  wire logic [3:0] ext_val,
   input  wire logic [3:0] ext_en,
   output logic      [3:0] pin_in
);
   logic [3:0] flt = 4'h0;

   // an undriven pad wanders, so a stale level can never pass for a real one
   always @(posedge clk)
   begin
      flt <= ~flt;
   end

   // device drive wins, then outside drive, then pull-up, else floating
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pullup_on) | (~pin_oe & ~ext_en & ~pullup_on & flt);
endmodule

// file: test/tb_gpio_port_a_and_port_regs.sv
// register and pin scenarios for the parallel port block
`timescale 1ns/100ps

module tb_gpio_port_a_and_port_regs;
   import gpa_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0]  avs_byteenable = 4'h1, kb_en = 4'h0, ext_val = 4'h0, ext_en = 4'h0;
   logic        avs_waitrequest;
   logic [3:0]  pin_in, pin_out, pin_oe, pu_on, kb_in;
   logic [7:0]  b_dir, c_dir, d_dir, e_lat, e_dir, c_pu, d_pu;
   int          errors = 0, num_checks = 0;
   logic [5:0]  addrs [8] = '{6'h10, 6'h14, 6'h18, 6'h1c, 6'h30, 6'h34, 6'h38, 6'h3c};
   logic [7:0]  masks [8] = '{8'h0f, 8'h3f, 8'h03, 8'h7f, 8'h03, 8'h0f, 8'h03, 8'h7f};

   always #10 clk = ~clk;

   gpa_port_regs gpa_port_regs_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_a_pin_in(pin_in), .port_a_pin_out(pin_out),
      .port_a_pin_oe(pin_oe), .port_a_pullup_on(pu_on), .keypad_irq_pin_enables(kb_en),
      .keypad_inputs(kb_in), .port_b_direction_out(b_dir), .port_c_direction_out(c_dir),
      .port_d_direction_out(d_dir), .port_e_latch_out(e_lat), .port_e_direction_out(e_dir),
      .port_c_pullup_out(c_pu), .port_d_pullup_out(d_pu));

   gpa_pad_model gpa_pad_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pu_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one bus access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= ~w;
      avs_writedata <= {24'h0, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk); // idle edge so no signal is assigned twice in one step
      if (n >= 20)
      begin
         errors++;
         tally_and_finish();
      end
   endtask

   // bounded wait covering the two-flop pin synchroniser and the keypad register
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values, then all-ones write read back through the masks
      foreach (addrs[i])
      begin
         bus(1'b0, addrs[i], 8'h00);
         check(q, 32'h0);
         bus(1'b1, addrs[i], 8'hff);
         bus(1'b0, addrs[i], 8'h00);
         check(q, {24'h0, masks[i]});
      end
      check({b_dir, c_dir, d_dir, e_dir}, 32'h3f037f03);
      check({16'h0, c_pu, d_pu}, 32'h0000037f);
      bus(1'b1, 6'h20, 8'hfe);
      bus(1'b0, 6'h20, 8'h00);
      check(q, 32'h02);
      // unmapped and misaligned places: answered, read zero, writes ignored
      bus(1'b1, 6'h04, 8'hff);
      bus(1'b0, 6'h04, 8'h00);
      check(q, 32'h0);
      bus(1'b0, 6'h11, 8'h00);
      check(q, 32'h0);
      bus(1'b1, 6'h11, 8'h00);
      bus(1'b0, 6'h10, 8'h00);
      check(q, 32'h0f);
      bus(1'b1, 6'h10, 8'h00);
      bus(1'b1, 6'h34, 8'h00);
      // latch loaded first, pins still inputs, outside drives 1010
      bus(1'b1, 6'h00, 8'hf5);
      ext_val <= 4'ha;
      ext_en  <= 4'hf;
      settle();
      check(pin_oe, 4'h0);
      check(pin_out, 4'h5);
      bus(1'b0, 6'h00, 8'h00);
      check(q, 32'h0a);
      // low two pins become outputs, read mixes latch and pad
      bus(1'b1, 6'h10, 8'h03);
      check(pin_oe, 4'h3);
      bus(1'b0, 6'h00, 8'h00);
      check(q, 32'h09);
      // pull-ups only on the input pins; released pads then read high
      bus(1'b1, 6'h34, 8'h0f);
      check(pu_on, 4'hc);
      ext_en <= 4'h0;
      settle();
      bus(1'b0, 6'h00, 8'h00);
      check(q, 32'h0d);
      // write with lane 0 disabled leaves the latch alone
      avs_byteenable <= 4'he;
      bus(1'b1, 6'h00, 8'h00);
      check(pin_out, 4'h5);
      avs_byteenable <= 4'h1;
      // keypad function on pin 0 forces it to input, pull-up follows
      kb_en <= 4'h1;
      settle();
      check(pin_oe, 4'h2);
      check(pu_on, 4'hd);
      check(kb_in, 4'h1);
      kb_en <= 4'h0;
      // second reset: latches kept, direction and pull-up cleared
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check(pin_out, 4'h5);
      check(e_lat, 8'h02);
      check(pin_oe, 4'h0);
      bus(1'b0, 6'h34, 8'h00);
      check(q, 32'h0);
      tally_and_finish();
   end
endmodule
